/* File: rtl/dmacm_top.sv */
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "dmacm_map.svh"
module dmacm_top
    import dmacm_pkg::*;
#(
    parameter int RAM_W = 16,
    parameter int CNT_W = 10
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // Peripheral trigger pulses, bit k is source code k+1
    input wire logic [10:0] trig_in,
    input wire logic serial_irq_in,
    // SFR side
    output logic [7:0] sfr_addr_out,
    output logic sfr_rd_out,
    output logic sfr_wr_out,
    output logic [15:0] sfr_wdata_out,
    input wire logic [15:0] sfr_rdata_in,
    // RAM side
    output logic [RAM_W-1:0] ram_addr_out,
    output logic ram_rd_out,
    output logic ram_wr_out,
    output logic [15:0] ram_wdata_out,
    input wire logic [15:0] ram_rdata_in,
    output logic wide_out,
    // Status and interrupts
    output logic [1:0] prio_level_out,
    output logic serial_enable_out,
    output logic serial_irq_out,
    output logic dma_irq_req_out,
    output logic irq_out
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] mode_r;
    logic en_r;
    logic act_r;
    logic [7:0] sfr_r;
    logic [RAM_W-1:0] ram_r;
    logic [CNT_W-1:0] cnt_r;
    logic [7:0] prl_r;
    logic [7:0] prh_r;
    logic [7:0] msk_r;
    logic [1:0] imk_r;
    logic ser_en_r;
    logic pend_r;
    logic [15:0] data_r;
    logic [15:0] rdata_r;
    dmacm_state_e st_r;
    dmacm_state_e st_nxt;
    logic [7:0] req_q;
    logic [1:0] ist_q;
    logic [7:0] req_set;
    logic [7:0] req_clr;
    logic [1:0] ist_set;
    logic [1:0] ist_clr;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic wr_mode;
    logic wr_ctrl;
    logic wr_setup;
    logic soft_fire;
    logic req_now;
    logic launch;
    logic done;
    logic last;
    logic dir;
    logic wide;
    logic hold;

    assign wr_mode = wr_in && addr_in == `DMACM_OFS_MODE;
    assign wr_ctrl = wr_in && addr_in == `DMACM_OFS_CTRL;
    // Setup writes ignored while the channel is off
    assign wr_setup = wr_in && en_r; // [R14]
    assign dir = mode_r[`DMACM_B_DIR];
    assign wide = mode_r[`DMACM_B_SIZE];
    assign hold = mode_r[`DMACM_B_HOLD];

    // ----------------------------------------------------------------
    // Trigger selection
    // ----------------------------------------------------------------
    dmacm_trig_if trig ();
    assign trig.code = mode_r[3:0];
    assign trig.src = trig_in;

    dmacm_trig_sel u_sel (
        .trig(trig)
    );

    // Soft trigger is a self-clearing strobe, never stored
    assign soft_fire = wr_mode && wr_setup && wdata_in[`DMACM_B_SOFT]; // [R2]
    assign req_now = en_r && act_r && (soft_fire || trig.hit); // [R2] [R17]
    assign launch = st_r == DMACM_IDLE && !hold && (req_now || pend_r)
        && en_r && act_r && cnt_r != '0; // [R5]
    assign done = st_r == DMACM_WR;
    assign last = cnt_r == CNT_W'(1);

    // ----------------------------------------------------------------
    // Mode and control
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            mode_r <= `DMACM_RST_MODE;
        end else if (wr_mode && wr_setup) begin
            mode_r <= {1'b0, wdata_in[6:0]};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            en_r <= 1'b0;
        end else if (wr_ctrl) begin
            en_r <= wdata_in[`DMACM_B_EN];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            act_r <= 1'b0;
        end else if (!en_r) begin
            // Needs enable already set in an earlier write
            act_r <= wr_ctrl && 1'b0; // [R13] [R14]
        end else if (done && last) begin
            act_r <= 1'b0; // [R13] [R16]
        end else if (wr_ctrl) begin
            act_r <= wdata_in[`DMACM_B_ACT] && wdata_in[`DMACM_B_EN]; // [R13]
        end
    end

    // A request seen while busy or held is kept for later
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pend_r <= 1'b0;
        end else if (!en_r || !act_r) begin
            pend_r <= 1'b0; // [R14]
        end else if (req_now && !launch) begin
            pend_r <= 1'b1; // [R5]
        end else if (launch) begin
            pend_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Address and count
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sfr_r <= 8'h00;
        end else if (wr_setup && addr_in == `DMACM_OFS_SFR) begin
            sfr_r <= wdata_in[7:0]; // [R8]
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ram_r <= '0;
        end else if (done) begin
            ram_r <= ram_r + (wide ? RAM_W'(2) : RAM_W'(1)); // [R16] [R4]
        end else if (wr_setup && addr_in == `DMACM_OFS_RAM) begin
            ram_r <= wdata_in[RAM_W-1:0]; // [R9]
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            cnt_r <= '0;
        end else if (done) begin
            cnt_r <= cnt_r - CNT_W'(1); // [R16]
        end else if (wr_setup && addr_in == `DMACM_OFS_CNT) begin
            cnt_r <= wdata_in[CNT_W-1:0]; // [R10]
        end
    end

    // ----------------------------------------------------------------
    // Mover: read source, capture, write destination
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            DMACM_IDLE: begin
                if (launch) begin
                    st_nxt = DMACM_RD;
                end
            end
            DMACM_RD: begin
                st_nxt = DMACM_CAP;
            end
            DMACM_CAP: begin
                st_nxt = DMACM_WR;
            end
            DMACM_WR: begin
                st_nxt = DMACM_IDLE;
            end
            default: begin
                st_nxt = DMACM_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in || !en_r) begin
            st_r <= DMACM_IDLE; // [R14]
        end else begin
            st_r <= st_nxt;
        end
    end

    // Byte moves clear the upper half so RAM sees zero
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            data_r <= 16'h0000;
        end else if (st_r == DMACM_CAP) begin
            data_r <= dir ? ram_rdata_in : sfr_rdata_in; // [R3]
            if (!wide) begin
                data_r[15:8] <= 8'h00; // [R4]
            end
        end
    end

    assign sfr_addr_out = sfr_r;
    assign ram_addr_out = ram_r;
    assign sfr_wdata_out = data_r;
    assign ram_wdata_out = data_r;
    assign wide_out = wide;
    assign sfr_rd_out = st_r == DMACM_RD && !dir; // [R3]
    assign ram_rd_out = st_r == DMACM_RD && dir; // [R3]
    assign sfr_wr_out = done && dir; // [R3]
    assign ram_wr_out = done && !dir; // [R3]

    // ----------------------------------------------------------------
    // Priority, mask and serial start
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            prl_r <= `DMACM_RST_PRIO;
            prh_r <= `DMACM_RST_PRIO;
        end else if (wr_in && addr_in == `DMACM_OFS_PRL) begin
            prl_r <= wdata_in[7:0];
        end else if (wr_in && addr_in == `DMACM_OFS_PRH) begin
            prh_r <= wdata_in[7:0];
        end
    end

    // Upper register bit is the level msb
    assign prio_level_out = {prh_r[`DMACM_B_PRIO], prl_r[`DMACM_B_PRIO]}; // [R1]

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            msk_r <= `DMACM_RST_MSK;
            imk_r <= `DMACM_RST_IMK;
        end else if (wr_in && addr_in == `DMACM_OFS_MSK) begin
            msk_r <= wdata_in[7:0]; // [R12]
        end else if (wr_in && addr_in == `DMACM_OFS_IMK) begin
            imk_r <= wdata_in[1:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ser_en_r <= 1'b0;
        end else if (wr_in && addr_in == `DMACM_OFS_SER) begin
            if (wdata_in[`DMACM_B_SSTART]) begin
                ser_en_r <= 1'b1; // [R15]
            end else if (wdata_in[`DMACM_B_SSTOP]) begin
                ser_en_r <= 1'b0;
            end
        end
    end

    assign serial_enable_out = ser_en_r;

    // ----------------------------------------------------------------
    // Request flags and interrupt status
    // ----------------------------------------------------------------
    always_comb begin
        req_set = 8'h00;
        req_clr = 8'h00;
        ist_set = 2'b00;
        ist_clr = 2'b00;
        req_set[`DMACM_B_SERF] = serial_irq_in; // [R11]
        req_set[`DMACM_B_DMAF] = done && last; // [R16]
        ist_set[`DMACM_B_IEND] = done && last; // [R16]
        ist_set[`DMACM_B_IBAD] = en_r && trig.bad; // [R7]
        if (wr_in && addr_in == `DMACM_OFS_REQ) begin
            req_set = req_set | wdata_in[7:0];
            req_clr = ~wdata_in[7:0]; // [R11]
        end
        if (wr_in && addr_in == `DMACM_OFS_IST) begin
            ist_clr = wdata_in[1:0];
        end
    end

    dmacm_sticky #(
        .W(8),
        .RST(8'h00)
    ) u_req (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .set_in(req_set),
        .clr_in(req_clr),
        .q_out(req_q)
    );

    dmacm_sticky #(
        .W(2),
        .RST(2'b00)
    ) u_ist (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .set_in(ist_set),
        .clr_in(ist_clr),
        .q_out(ist_q)
    );

    // Mask bit high blocks servicing
    assign serial_irq_out = req_q[`DMACM_B_SERF] && !msk_r[`DMACM_B_SERF]; // [R12]
    assign dma_irq_req_out = req_q[`DMACM_B_DMAF] && !msk_r[`DMACM_B_DMAF];
    assign irq_out = |(ist_q & ~imk_r);

    // ----------------------------------------------------------------
    // Read back, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rdata_r <= 16'h0000;
        end else if (rd_in) begin
            unique case (addr_in)
                `DMACM_OFS_MODE: rdata_r <= {8'h00, mode_r};
                `DMACM_OFS_CTRL: rdata_r <= {8'h00, en_r, 6'h00, act_r}; // [R13]
                `DMACM_OFS_SFR: rdata_r <= {8'h00, sfr_r};
                `DMACM_OFS_RAM: rdata_r <= 16'(ram_r);
                `DMACM_OFS_CNT: rdata_r <= 16'(cnt_r);
                `DMACM_OFS_PRL: rdata_r <= {8'h00, prl_r};
                `DMACM_OFS_PRH: rdata_r <= {8'h00, prh_r};
                `DMACM_OFS_REQ: rdata_r <= {8'h00, req_q}; // [R11]
                `DMACM_OFS_MSK: rdata_r <= {8'h00, msk_r};
                `DMACM_OFS_SER: rdata_r <= {15'h0000, ser_en_r}; // [R15]
                `DMACM_OFS_IST: rdata_r <= {14'h0000, ist_q};
                `DMACM_OFS_IMK: rdata_r <= {14'h0000, imk_r};
                default: rdata_r <= 16'h0000;
            endcase
        end
    end

    assign rdata_out = rdata_r;
endmodule // dmacm_top

/* File: rtl/dmacm_map.svh */
`ifndef DMACM_MAP_SVH
`define DMACM_MAP_SVH
// Summary of operation
// R1 - Priority level from bit 3 of both registers
// R2 - Soft trigger starts transfer when channel enabled
// R3 - Direction: 0 SFR to RAM, 1 RAM to SFR
// R4 - Size bit: 0 byte, 1 halfword
// R5 - Hold bit keeps start requests pending
// R6 - Source code zero: software trigger only
// R7 - Source codes 1 to 11 pick peripheral events
// R8 - SFR address register holds low address byte
// R9 - RAM address register holds RAM address
// R10 - Count register holds number of transfers
// R11 - Serial request flag reads one while pending
// R12 - Serial mask bit one blocks servicing
// R13 - Active set only after enable; clears at end
// R14 - Enable low stops channel and blocks setup
// R15 - Serial start trigger sets enabled status
// R16 - Advance address, decrement count, flag at zero
// R17 - One trigger pulse gives one transfer
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DMACM_OFS_MODE 4'h0
`define DMACM_OFS_CTRL 4'h1
`define DMACM_OFS_SFR 4'h2
`define DMACM_OFS_RAM 4'h3
`define DMACM_OFS_CNT 4'h4
`define DMACM_OFS_PRL 4'h5
`define DMACM_OFS_PRH 4'h6
`define DMACM_OFS_REQ 4'h7
`define DMACM_OFS_MSK 4'h8
`define DMACM_OFS_SER 4'h9
`define DMACM_OFS_IST 4'hA
`define DMACM_OFS_IMK 4'hB
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DMACM_B_SOFT 7
`define DMACM_B_DIR 6
`define DMACM_B_SIZE 5
`define DMACM_B_HOLD 4
`define DMACM_B_EN 7
`define DMACM_B_ACT 0
`define DMACM_B_PRIO 3
`define DMACM_B_SERF 5
`define DMACM_B_DMAF 3
`define DMACM_B_SSTART 0
`define DMACM_B_SSTOP 1
`define DMACM_B_IEND 0
`define DMACM_B_IBAD 1
`define DMACM_SRC_MAX 4'hB
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DMACM_RST_MODE 8'h00
`define DMACM_RST_PRIO 8'hFF
`define DMACM_RST_MSK 8'hFF
`define DMACM_RST_IMK 2'h3
`endif

/* File: rtl/dmacm_pkg.sv */
package dmacm_pkg;
    // Mover states, one-hot
    typedef enum logic [3:0] {
        DMACM_IDLE = 4'b0001,
        DMACM_RD = 4'b0010,
        DMACM_CAP = 4'b0100,
        DMACM_WR = 4'b1000
    } dmacm_state_e;
    typedef logic [3:0] dmacm_src_t;
endpackage

/* File: rtl/dmacm_trig_if.sv */
`timescale 1ns/10ps
interface dmacm_trig_if;
    logic [3:0] code;
    logic [10:0] src;
    logic hit;
    logic bad;
    modport sel (input code, input src, output hit, output bad);
    modport ctl (output code, output src, input hit, input bad);
endinterface

/* File: rtl/dmacm_trig_sel.sv */
`timescale 1ns/10ps
`include "dmacm_map.svh"
module dmacm_trig_sel
    import dmacm_pkg::*;
(
    dmacm_trig_if.sel trig
);
    always_comb begin
        trig.hit = 1'b0;
        trig.bad = 1'b0;
        if (trig.code == 4'h0) begin
            trig.hit = 1'b0; // [R6]
        end else if (trig.code <= `DMACM_SRC_MAX) begin
            trig.hit = trig.src[trig.code - 4'h1]; // [R7]
        end else begin
            trig.bad = 1'b1; // [R7]
        end
    end
endmodule // dmacm_trig_sel

/* File: rtl/dmacm_sticky.sv */
`timescale 1ns/10ps
module dmacm_sticky
    import dmacm_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Flag control
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] q_out
);
    // Set beats clear so a same-cycle event is kept
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            q_out <= RST;
        end else begin
            q_out <= (q_out & ~clr_in) | set_in;
        end
    end
endmodule // dmacm_sticky

/* File: test/dmacm_assertions.sv */
`timescale 1ns/10ps
module dmacm_assertions (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic serial_irq_in,
    // Mover
    input wire logic sfr_rd_out,
    input wire logic sfr_wr_out,
    input wire logic [15:0] sfr_rdata_in,
    input wire logic ram_rd_out,
    input wire logic ram_wr_out,
    input wire logic [15:0] ram_wdata_out,
    input wire logic wide_out,
    // Status
    input wire logic [1:0] prio_level_out,
    input wire logic serial_enable_out,
    input wire logic serial_irq_out,
    input wire logic dma_irq_req_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);
    prio_high_a: assert property (
        wr_in && addr_in == 4'h6 |=> prio_level_out[1] == $past(wdata_in[3]))
        else $error("priority msb wrong");
    prio_low_a: assert property (
        wr_in && addr_in == 4'h5 |=> prio_level_out[0] == $past(wdata_in[3]))
        else $error("priority lsb wrong");
    to_ram_a: assert property (
        sfr_rd_out && !wr_in ##1 !wr_in |=> ram_wr_out && !sfr_wr_out)
        else $error("sfr read not followed by ram write");
    to_sfr_a: assert property (
        ram_rd_out && !wr_in ##1 !wr_in |=> sfr_wr_out && !ram_wr_out)
        else $error("ram read not followed by sfr write");
    narrow_zero_a: assert property (
        ram_wr_out && !wide_out |-> ram_wdata_out[15:8] == 8'h00)
        else $error("byte transfer upper half not zero");
    data_pass_a: assert property (
        ram_wr_out && $past(sfr_rd_out, 2) |-> ram_wdata_out ==
        (wide_out ? $past(sfr_rdata_in) : {8'h00, $past(sfr_rdata_in[7:0])}))
        else $error("ram data differs from sfr data");
    one_per_four_a: assert property (
        sfr_rd_out |=> !sfr_rd_out [*3])
        else $error("transfers too close");
    serial_rise_a: assert property (
        $rose(serial_irq_out) |-> $past(serial_irq_in) || $past(wr_in))
        else $error("serial request without cause");
    end_rise_a: assert property (
        $rose(dma_irq_req_out) |-> $past(ram_wr_out) || $past(sfr_wr_out) || $past(wr_in))
        else $error("end request not after a transfer");
    soft_reads_a: assert property (
        rd_in && addr_in == 4'h0 |=> !rdata_out[7])
        else $error("soft trigger bit read as one");
    stop_mover_a: assert property (
        wr_in && addr_in == 4'h1 && !wdata_in[7] |=> ##1 (!sfr_rd_out && !ram_rd_out) [*3])
        else $error("mover ran while disabled");
    serial_go_a: assert property (
        wr_in && addr_in == 4'h9 && wdata_in[1:0] == 2'b01 |=> serial_enable_out)
        else $error("serial start did not enable");
endmodule // dmacm_assertions
bind dmacm_top dmacm_assertions chk (
    .sys_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .serial_irq_in, .sfr_rd_out, .sfr_wr_out, .sfr_rdata_in, .ram_rd_out, .ram_wr_out,
    .ram_wdata_out, .wide_out, .prio_level_out, .serial_enable_out, .serial_irq_out,
    .dma_irq_req_out
);

/* File: test/dmacm_periph_model.sv */
`timescale 1ns/10ps
module dmacm_periph_model (
    // Clock
    input wire logic sys_clk_in,
    // SFR side
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_rd_in,
    input wire logic sfr_wr_in,
    input wire logic [15:0] sfr_wdata_in,
    output logic [15:0] sfr_rdata_out,
    // RAM side
    input wire logic [15:0] ram_addr_in,
    input wire logic ram_rd_in,
    input wire logic ram_wr_in,
    input wire logic [15:0] ram_wdata_in,
    output logic [15:0] ram_rdata_out
);
    logic [15:0] mem [0:63];
    logic [7:0] sfr_reads = 8'h00;
    logic [7:0] sfr_writes = 8'h00;
    logic [7:0] ram_writes = 8'h00;
    logic [15:0] sfr_last = 16'h0000;
    initial sfr_rdata_out = 16'h0000;
    initial ram_rdata_out = 16'h0000;
    // Read data valid one cycle only; toggles otherwise so data taken one cycle late never matches
    always @(posedge sys_clk_in) begin
        sfr_rdata_out <= sfr_rd_in ? {8'hC3, sfr_addr_in + sfr_reads} : ~sfr_rdata_out;
        sfr_reads <= sfr_reads + {7'h00, sfr_rd_in};
        ram_rdata_out <= ram_rd_in ? mem[ram_addr_in[5:0]] : ~ram_rdata_out;
        if (ram_wr_in) begin
            mem[ram_addr_in[5:0]] <= ram_wdata_in;
            ram_writes <= ram_writes + 8'h01;
        end
        if (sfr_wr_in) begin
            sfr_last <= sfr_wdata_in;
            sfr_writes <= sfr_writes + 8'h01;
        end
    end
endmodule // dmacm_periph_model

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [10:0] trig_in = 11'h000;
    logic serial_irq_in = 1'b0;
    logic [15:0] rdata_out, sfr_wdata_out, sfr_rdata_in, ram_addr_out, ram_wdata_out, ram_rdata_in;
    logic [7:0] sfr_addr_out;
    logic [1:0] prio_level_out;
    logic sfr_rd_out, sfr_wr_out, ram_rd_out, ram_wr_out, wide_out;
    logic serial_enable_out, serial_irq_out, dma_irq_req_out, irq_out;
    logic [15:0] v;
    int fails = 0;
    int comparisons = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    dmacm_top uut (.sys_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .trig_in, .serial_irq_in, .sfr_addr_out, .sfr_rd_out, .sfr_wr_out, .sfr_wdata_out,
        .sfr_rdata_in, .ram_addr_out, .ram_rd_out, .ram_wr_out, .ram_wdata_out, .ram_rdata_in,
        .wide_out, .prio_level_out, .serial_enable_out, .serial_irq_out, .dma_irq_req_out,
        .irq_out);
    dmacm_periph_model pm (.sys_clk_in, .sfr_addr_in(sfr_addr_out), .sfr_rd_in(sfr_rd_out),
        .sfr_wr_in(sfr_wr_out), .sfr_wdata_in(sfr_wdata_out), .sfr_rdata_out(sfr_rdata_in),
        .ram_addr_in(ram_addr_out), .ram_rd_in(ram_rd_out), .ram_wr_in(ram_wr_out),
        .ram_wdata_in(ram_wdata_out), .ram_rdata_out(ram_rdata_in));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One bus cycle; read data taken in the following cycle
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= w;
        rd_in <= !w;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask
    // Pulse, then room for one full four-cycle transfer
    task automatic pulse(input logic [10:0] t, input logic s);
        trig_in <= t;
        serial_irq_in <= s;
        @(posedge sys_clk_in);
        trig_in <= 11'h000;
        serial_irq_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic wait_end();
        int i;
        for (i = 0; i < 50 && dma_irq_req_out !== 1'b1; i++) @(posedge sys_clk_in);
        if (i == 50) begin
            fails++;
            wrap_up();
        end
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] tab [0:12];
        tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00,
            8'h00, 8'h03, 8'h00};
        for (int i = 0; i < 13; i++) begin
            acc(0, i[3:0], 16'h0000);
            chk(v, {8'h00, tab[i]});
        end
        chk(prio_level_out, 2'h3);
        acc(1, 4'h0, 16'h0080);
        acc(0, 4'h0, 16'h0000);
        chk(v, 16'h0000);
        acc(1, 4'h1, 16'h0081);
        acc(0, 4'h1, 16'h0000);
        chk(v, 16'h0080);
        acc(1, 4'h1, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_prio();
        for (int i = 0; i < 4; i++) begin
            acc(1, 4'h6, {12'h000, i[1], 3'b000});
            acc(1, 4'h5, {12'h000, i[0], 3'b000});
            chk(prio_level_out, i[1:0]);
        end
        $display("test priority done");
    endtask
    task automatic t_serial();
        pulse(11'h000, 1'b1);
        acc(0, 4'h7, 16'h0000);
        chk(v[5], 1'b1);
        chk(serial_irq_out, 1'b0);
        acc(1, 4'h8, 16'h00DF);
        chk(serial_irq_out, 1'b1);
        acc(1, 4'h7, 16'h0000);
        acc(0, 4'h7, 16'h0000);
        chk(v[5], 1'b0);
        acc(1, 4'h9, 16'h0001);
        chk(serial_enable_out, 1'b1);
        acc(0, 4'h9, 16'h0000);
        chk(v[0], 1'b1);
        acc(1, 4'h9, 16'h0002);
        chk(serial_enable_out, 1'b0);
        $display("test serial done");
    endtask
    task automatic t_rx();
        logic [7:0] n;
        logic [7:0] r0;
        acc(1, 4'h1, 16'h0080);
        acc(1, 4'h0, 16'h0006);
        acc(1, 4'h2, 16'h0010);
        acc(1, 4'h3, 16'h0020);
        acc(1, 4'h4, 16'h0005);
        acc(1, 4'h8, 16'h00F7);
        acc(1, 4'hB, 16'h0000);
        acc(1, 4'h1, 16'h0081);
        n = pm.ram_writes;
        r0 = pm.sfr_reads;
        pulse(11'h010, 1'b0);
        chk(pm.ram_writes, n);
        for (int k = 0; k < 5; k++) pulse(11'h020, 1'b0);
        wait_end();
        chk(pm.ram_writes - n, 16'h0005);
        for (int k = 0; k < 5; k++) begin
            chk(pm.mem[6'h20 + k], {8'h00, 8'h10 + r0 + k[7:0]});
        end
        chk(irq_out, 1'b1);
        acc(0, 4'h1, 16'h0000);
        chk(v, 16'h0080);
        acc(0, 4'h4, 16'h0000);
        chk(v, 16'h0000);
        $display("test receive done");
    endtask
    task automatic t_tx();
        logic [7:0] n;
        pm.mem[6'h30] = 16'hBEEF;
        pm.mem[6'h32] = 16'h1234;
        acc(1, 4'h7, 16'h0000);
        acc(1, 4'hA, 16'h0003);
        chk(irq_out, 1'b0);
        acc(1, 4'h0, 16'h0060);
        acc(1, 4'h3, 16'h0030);
        acc(1, 4'h4, 16'h0002);
        acc(1, 4'h1, 16'h0081);
        n = pm.sfr_writes;
        pulse(11'h7FF, 1'b0);
        chk(pm.sfr_writes, n);
        acc(1, 4'h0, 16'h00E0);
        pulse(11'h000, 1'b0);
        chk(pm.sfr_last, 16'hBEEF);
        chk(wide_out, 1'b1);
        acc(1, 4'h0, 16'h00E0);
        wait_end();
        chk(pm.sfr_last, 16'h1234);
        $display("test transmit done");
    endtask
    task automatic t_hold();
        logic [7:0] n;
        acc(1, 4'h7, 16'h0000);
        acc(1, 4'h0, 16'h0016);
        acc(1, 4'h3, 16'h0028);
        acc(1, 4'h4, 16'h0001);
        acc(1, 4'h1, 16'h0081);
        n = pm.ram_writes;
        pulse(11'h020, 1'b0);
        pulse(11'h020, 1'b0);
        chk(pm.ram_writes, n);
        acc(1, 4'h0, 16'h0006);
        pulse(11'h000, 1'b0);
        chk(pm.ram_writes - n, 16'h0001);
        acc(1, 4'hA, 16'h0003);
        acc(1, 4'h0, 16'h000C);
        pulse(11'h7FF, 1'b0);
        acc(0, 4'hA, 16'h0000);
        chk(v[1], 1'b1);
        acc(1, 4'h1, 16'h0000);
        acc(1, 4'h0, 16'h0080);
        acc(0, 4'h0, 16'h0000);
        chk(v, 16'h000C);
        $display("test hold done");
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        t_reset();
        t_prio();
        t_serial();
        t_rx();
        t_tx();
        t_hold();
        wrap_up();
    end
endmodule // tb_top
